// >>> rtl/dsw_pkg.sv
// shared constants for the switch/host handshake ends
package dsw_pkg;
  // host acknowledge pulse length
  localparam int ACK_PULSE_NS = 5000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACK_CYCLES = ACK_PULSE_NS / CLK_PERIOD_NS;
  // host waits this long after releasing before polling again
  localparam int REARM_NS = 5000;
  localparam int REARM_CYCLES = REARM_NS / CLK_PERIOD_NS;
  // contact debounce settle time
  localparam int DEBOUNCE_NS = 2000;
  localparam int DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // device accepts an ack after this many minus one consecutive low samples
  localparam int ACK_SEEN_CYCLES = 4;
  localparam int CNT_W = 12;
  // reset levels
  localparam logic TOGGLE_RST = 1'b1;
  localparam logic IDLE_HIGH_RST = 1'b1;
endpackage

// >>> rtl/dsw_link_if.sv
// single-wire request/acknowledge link between switch and host
`timescale 1ns/1ps
interface dsw_link_if;
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;
  logic request_ack_line;
  // wired line: pull-up unless someone drives low
  assign request_ack_line = (dev_oe && !dev_out) || (host_oe && !host_out)
    ? 1'b0 : 1'b1;
  modport device (output dev_out, output dev_oe, input request_ack_line);
  modport host (output host_out, output host_oe, input request_ack_line);
endinterface

// >>> rtl/dsw_switch_end.sv
// debounced switch outputs with handshake request line
//
// Function
// - request line low idle, high pressed
// - idle-high output low while pressed
// - toggle output flips on each activation
// - toggle output high after power-up
// - device drives line low when idle
// - press releases line, pull-up requests service
// - host reads high line as request
// - host drives line low for 5 us
// - host enables output before driving low
// - ack seen: drive low until release
// - no new request before debounced release
// - host returns to input any time
// - host ignores low line
//
// The contact is filtered by a stability counter. Only a level that
// holds for the full window reaches the outputs, so short glitches
// never move the momentary, toggle or request outputs.
// The request line is open-drain on this side: the device either
// pulls it low or lets go, and a pull-up raises it as the request.
// While the request stands, every clock samples the wire, and a run
// of low samples counts as the host's acknowledge. The device then
// pulls low again and keeps it low until the release is debounced,
// so the host needs no further polling for that press.
// Limitation: a release before any acknowledge simply drops the
// request, so a host that polls slowly may miss a very short press.
`timescale 1ns/1ps
module dsw_switch_end
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // mechanical contact, high when pressed
  input wire logic contact_raw,
  // link
  dsw_link_if.device link,
  // clean outputs
  output logic idle_high_momentary_out,
  output logic push_toggle_out,
  output logic pressed_clean
);

  // device states, one-hot:
  // idle - line pulled low, waiting for a debounced press
  // request - line let go, watching for the acknowledge
  // acked - line pulled low again, waiting for the release
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_ACKED = 3'b100
  } dsw_dev_state_t;

  // handshake state
  dsw_dev_state_t state_r, state_nxt;
  // debounced level and its stability counter
  logic deb_r, deb_nxt;
  logic [CNT_W-1:0] deb_cnt_r, deb_cnt_nxt;
  // consecutive low samples of the wire while requesting
  logic [2:0] low_cnt_r, low_cnt_nxt;
  // device drives the wire low while this is set
  logic oe_r, oe_nxt;
  // idle-high momentary and toggle outputs
  logic nh_r, nh_nxt;
  logic tg_r, tg_nxt;

  // debounce: accept a new contact level once stable long enough;
  // any sample back at the old level restarts the count, so a
  // bouncing contact never gets through half way
  always_comb
  begin
    deb_nxt = deb_r;
    deb_cnt_nxt = '0;
    if (contact_raw != deb_r)
    begin
      deb_cnt_nxt = deb_cnt_r + 1'b1;
      if (deb_cnt_r == CNT_W'(DEBOUNCE_CYCLES - 1))
      begin
        deb_nxt = contact_raw;
        deb_cnt_nxt = '0;
      end
    end
  end

  // debounce registers; the level starts as released
  // so no false press is seen after reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      deb_r <= 1'b0;
      deb_cnt_r <= '0;
    end
    else
    begin
      deb_r <= deb_nxt;
      deb_cnt_r <= deb_cnt_nxt;
    end
  end

  // handshake state: request, wait for ack, hold low until release;
  // the wire is driven low by default, let go when entering and while holding the request
  always_comb
  begin
    state_nxt = state_r;
    low_cnt_nxt = '0;
    oe_nxt = 1'b1;
    case (state_r)
      ST_IDLE:
      begin
        if (deb_nxt)
        begin
          state_nxt = ST_REQ;
          oe_nxt = 1'b0;
        end
      end
      ST_REQ:
      begin
        oe_nxt = 1'b0;
        // sample every clock, far faster than the pulse
        // a few consecutive lows are needed, so a single low
        // glitch on the wire is not taken as an acknowledge;
        // a high sample restarts the run
        if (!link.request_ack_line)
          low_cnt_nxt = low_cnt_r + 3'd1;
        if (!deb_nxt)
        begin
          state_nxt = ST_IDLE;
          oe_nxt = 1'b1;
        end
        else if (low_cnt_r == 3'(ACK_SEEN_CYCLES - 1))
        begin
          state_nxt = ST_ACKED;
          oe_nxt = 1'b1;
        end
      end
      ST_ACKED:
      begin
        // wire stays low even if the contact is still held,
        // a new request waits for a debounced release
        if (!deb_nxt)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // handshake registers; the wire is pulled low from reset on,
  // so the host sees idle before the first press
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      low_cnt_r <= '0;
      oe_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      low_cnt_r <= low_cnt_nxt;
      oe_r <= oe_nxt;
    end
  end

  // momentary and toggle outputs follow the debounced level
  always_comb
  begin
    nh_nxt = !deb_nxt;
    tg_nxt = tg_r;
    // flip only on the debounced rising edge, so a held press
    // or a bouncing release never toggles twice
    if (deb_nxt && !deb_r)
      tg_nxt = !tg_r;
  end

  // output registers; the toggle starts high before any press,
  // they move on the same edge as the debounced level
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      nh_r <= IDLE_HIGH_RST;
      tg_r <= TOGGLE_RST;
    end
    else
    begin
      nh_r <= nh_nxt;
      tg_r <= tg_nxt;
    end
  end

  // outputs straight from their flip-flops; the device only ever
  // pulls the wire low, so its data bit is tied low and the
  // enable alone decides between driving and letting go
  assign link.dev_out = 1'b0;
  assign link.dev_oe = oe_r;
  assign idle_high_momentary_out = nh_r;
  assign push_toggle_out = tg_r;
  assign pressed_clean = deb_r;

endmodule

// >>> rtl/dsw_host_end.sv
// host side of the single-wire request/acknowledge link
`timescale 1ns/1ps
module dsw_host_end
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link
  dsw_link_if.host link,
  // user side
  input wire logic poll_en,
  output logic service_req,
  output logic host_busy
);

  typedef enum logic [3:0] {
    HS_WATCH = 4'b0001,
    HS_SETOUT = 4'b0010,
    HS_PULSE = 4'b0100,
    HS_REARM = 4'b1000
  } dsw_host_state_t;

  dsw_host_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic oe_r, oe_nxt;
  logic out_r, out_nxt;
  logic req_r, req_nxt;
  logic busy_r, busy_nxt;

  // poll, acknowledge with a timed low pulse, then release
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = '0;
    oe_nxt = 1'b0;
    out_nxt = 1'b1;
    req_nxt = 1'b0;
    case (state_r)
      HS_WATCH:
      begin
        // low line means nothing to do
        if (poll_en && link.request_ack_line)
        begin
          state_nxt = HS_SETOUT;
          oe_nxt = 1'b1;
          req_nxt = 1'b1;
        end
      end
      HS_SETOUT:
      begin
        oe_nxt = 1'b1;
        out_nxt = 1'b0;
        state_nxt = HS_PULSE;
      end
      HS_PULSE:
      begin
        oe_nxt = 1'b1;
        out_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(ACK_CYCLES - 1))
        begin
          state_nxt = HS_REARM;
          oe_nxt = 1'b0;
          out_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      HS_REARM:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(REARM_CYCLES - 1))
          state_nxt = HS_WATCH;
      end
      default:
        state_nxt = HS_WATCH;
    endcase
    busy_nxt = (state_nxt != HS_WATCH);
  end

  // registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= HS_WATCH;
      cnt_r <= '0;
      oe_r <= 1'b0;
      out_r <= 1'b1;
      req_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
      req_r <= req_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign link.host_oe = oe_r;
  assign link.host_out = out_r;
  assign service_req = req_r;
  assign host_busy = busy_r;

endmodule

// >>> sim/dsw_sva.sv
// assertions on the switch/host link wires
`timescale 1ns/1ps
module dsw_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link wires
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic request_ack_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // device side of the wire
  a_idle_drive_low: assert property (
    dev_oe |-> !dev_out && !request_ack_line)
    else $error("device drive not low");
  a_line_follows_dev: assert property (
    !host_oe |-> request_ack_line == !dev_oe)
    else $error("line not set by device");
  a_ack_taken: assert property (
    (!dev_oe && !request_ack_line)[*4] |=> dev_oe)
    else $error("ack not taken");
  a_ack_hold: assert property (
    $rose(dev_oe) && host_oe |=> dev_oe[*8])
    else $error("line released after ack");
  // host side of the wire
  a_oe_first: assert property ($rose(host_oe) |-> host_out)
    else $error("host drove low before enable");
  a_pulse_min: assert property ($fell(host_out) |=> !host_out[*8])
    else $error("ack pulse short");
  a_pulse_end: assert property (
    $fell(host_out) |-> ##[620:630] $rose(host_out))
    else $error("ack pulse length");
  a_host_rearm: assert property ($fell(host_oe) |=> !host_oe[*8])
    else $error("host re-drove early");
  // main scenarios
  c_request: cover property ($fell(dev_oe));
  c_ack: cover property ($rose(host_oe));
  c_latched: cover property ($rose(dev_oe) && host_oe);
endmodule

// >>> sim/dsw_tb.sv
// bench for the switch and host ends
`timescale 1ns/1ps
module dsw_tb import dsw_pkg::*;;
  logic clk_sys = 0, rst = 1, contact_raw = 0, poll_en = 0, tgl = TOGGLE_RST;
  logic ih, tg, pc, pc_d, sreq, busy;
  logic [31:0] seed = 9;
  logic [2:0] q[$];
  int failures, checked, nreq;
  dsw_link_if link ();
  dsw_switch_end dsw_switch_end_i (.clk_sys, .rst, .contact_raw, .link(link),
    .idle_high_momentary_out(ih), .push_toggle_out(tg), .pressed_clean(pc));
  dsw_host_end dsw_host_end_i (.clk_sys, .rst, .link(link), .poll_en,
    .service_req(sreq), .host_busy(busy));
  dsw_sva dsw_sva_i (.clk_sys, .rst, .dev_out(link.dev_out),
    .dev_oe(link.dev_oe), .host_out(link.host_out), .host_oe(link.host_oe),
    .request_ack_line(link.request_ack_line));
  // clock
  initial
    forever #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(logic [2:0] seen, logic [2:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t saw %b want %b", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // outputs against oldest note on each debounced change, requests counted
  always @(posedge clk_sys)
  begin
    pc_d <= pc;
    if (!rst && pc !== pc_d)
      check({pc, ih, tg}, q.pop_front());
    if (sreq === 1'b1)
      nreq++;
  end
  // watchdog
  initial
  begin
    #100us;
    failures++;
    report_and_stop();
  end
  // glitch, then press and release without and with host polling
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    check({ih, tg, link.request_ack_line}, 3'b110);
    for (int i = 0; i < 3; i++)
    begin
      poll_en <= (i > 0);
      contact_raw <= 1;
      repeat (20 + rnd() % 200) @(posedge clk_sys);
      contact_raw <= 0;
      repeat (300) @(posedge clk_sys);
      contact_raw <= 1;
      tgl = !tgl;
      q.push_back({2'b10, tgl});
      repeat (900) @(posedge clk_sys);
      check({1'b0, link.request_ack_line, busy}, {1'b0, i == 0, i > 0});
      contact_raw <= 0;
      q.push_back({2'b01, tgl});
      repeat (900) @(posedge clk_sys);
      check({link.request_ack_line, 2'(nreq)}, {1'b0, 2'(i)});
      $display("test %0d done", i);
    end
    check(3'(q.size()), 3'd0);
    report_and_stop();
  end
endmodule
